//--- pkg/hlb_pkg.sv
// Constants and types shared by the loop and brake configuration block
package hlb_pkg;
   // ---------------------------------------------------------------
   // Register port
   // ---------------------------------------------------------------
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;
   localparam logic [7:0] OFS_LOOP_BRAKE = 8'h08;
   localparam logic [7:0] OFS_SUPPLY = 8'h09;
   localparam logic [7:0] RST_LOOP_BRAKE = 8'h88;
   localparam logic [7:0] RST_SUPPLY = 8'h00;
   localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

   // ---------------------------------------------------------------
   // Field positions of the loop and brake register
   // ---------------------------------------------------------------
   localparam int unsigned BIT_LRA_SELECT = 7;
   localparam int unsigned BIT_OPEN_LOOP = 6;
   localparam int unsigned BIT_HYBRID = 5;
   localparam int unsigned BIT_OPEN_LOOP_AUTO_STOP = 4;
   localparam int unsigned BIT_STOP_BEFORE_IDLE = 3;
   localparam int unsigned BIT_SLOPE_GATE = 2;

   // ---------------------------------------------------------------
   // Field positions of the supply register
   // ---------------------------------------------------------------
   localparam int unsigned POS_SUPPLY_SAVER = 6;
   localparam int unsigned W_SUPPLY_SAVER = 2;
   localparam int unsigned POS_LOW_SUPPLY = 0;
   localparam int unsigned W_LOW_SUPPLY = 3;

   // ---------------------------------------------------------------
   // Fixed thresholds
   // ---------------------------------------------------------------
   localparam logic [7:0] MOTION_THRESH = 8'h10;
   localparam logic [8:0] SLOPE_THRESH = 9'h020;

   // ---------------------------------------------------------------
   // Drive sequencing states
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      HLB_RUN,
      HLB_BRAKE,
      HLB_STANDBY
   } hlb_state_t;
endpackage

//--- pkg/hlb_gate_if.sv
// Link between the core and the motion and slope gate
interface hlb_gate_if;
   logic signed [7:0] sample;
   logic sample_valid;
   logic [7:0] bemf;
   logic moving;
   logic slope_big;

   modport gate (input sample, input sample_valid, input bemf, output moving, output slope_big);
   modport core (output sample, output sample_valid, output bemf, input moving, input slope_big);
endinterface

//--- src/hlb_gate.sv
// Motion and input slope detection against fixed thresholds
module hlb_gate #(
   parameter logic [7:0] MOTION_LVL = hlb_pkg::MOTION_THRESH,
   parameter logic [8:0] SLOPE_LVL = hlb_pkg::SLOPE_THRESH
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   hlb_gate_if.gate gif
);
   import hlb_pkg::*;

   logic signed [7:0] prev_r;
   logic signed [7:0] prev_nxt;
   logic signed [8:0] diff;
   logic [8:0] mag;

   // ---------------------------------------------------------------
   // Slope and motion decisions
   // ---------------------------------------------------------------
   always_comb begin
      prev_nxt = gif.sample_valid ? gif.sample : prev_r;
      diff = $signed({gif.sample[7], gif.sample}) - $signed({prev_r[7], prev_r});
      mag = diff[8] ? 9'(-diff) : 9'(diff);
   end

   assign gif.slope_big = gif.sample_valid && (mag >= SLOPE_LVL);
   assign gif.moving = gif.bemf >= MOTION_LVL;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prev_r <= 8'sh00;
      end else begin
         prev_r <= prev_nxt;
      end
   end
endmodule

//--- src/hlb_top.sv
// Loop selection, open loop braking and brake before standby
// Behaviour
// - Loop select bit: zero closed, one open
// - Bit five picks full closed or hybrid
// - Auto stop, sample not positive: close, brake
// - Auto stop, positive sample: keep open drive
// - Auto stop off at reset, no braking
// - Stop before idle while playing: brake, standby
// - Stop before idle clear: standby at once
// - Brake only if actuator moving, else standby
// - Slope gate: open unless step large enough
// - Slope gate ignored without hybrid loop
module hlb_top (
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic [hlb_pkg::ADDR_W-1:0] reg_addr_i,
   input wire logic [hlb_pkg::DATA_W-1:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [hlb_pkg::DATA_W-1:0] reg_rdata_o,
   input wire logic signed [7:0] sample_i,
   input wire logic sample_valid_i,
   input wire logic [7:0] bemf_i,
   input wire logic playing_i,
   input wire logic idle_timer_req_i,
   input wire logic pin_level_mode_i,
   input wire logic trigger_or_irq_pin_i,
   input wire logic wake_i,
   output logic loop_open_o,
   output logic hybrid_active_o,
   output logic brake_o,
   output logic signed [7:0] drive_sample_o,
   output logic standby_o,
   output logic lra_select_o,
   output logic [1:0] supply_saver_enable_o,
   output logic [2:0] low_supply_threshold_o
);
   import hlb_pkg::*;

   // ---------------------------------------------------------------
   // Reset release and pin synchroniser
   // ---------------------------------------------------------------
   logic [1:0] rst_sync_r;
   logic rst_n;
   logic pin_meta_r;
   logic pin_sync_r;
   logic pin_prev_r;
   logic pin_release;
   logic standby_req;

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta_r <= 1'b0;
         pin_sync_r <= 1'b0;
         pin_prev_r <= 1'b0;
      end else begin
         pin_meta_r <= trigger_or_irq_pin_i;
         pin_sync_r <= pin_meta_r;
         pin_prev_r <= pin_sync_r;
      end
   end

   // Enable released on the level trigger pin asks for standby
   assign pin_release = pin_level_mode_i && pin_prev_r && !pin_sync_r;
   assign standby_req = idle_timer_req_i || pin_release;

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   logic [7:0] loop_cfg_r;
   logic [7:0] loop_cfg_nxt;
   logic [7:0] supply_cfg_r;
   logic [7:0] supply_cfg_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
      hit = (addr == ofs);
   endfunction

   always_comb begin
      loop_cfg_nxt = loop_cfg_r;
      supply_cfg_nxt = supply_cfg_r;
      rdata_nxt = rdata_r;
      if (reg_wr_i && hit(reg_addr_i, OFS_LOOP_BRAKE)) begin
         loop_cfg_nxt = reg_wdata_i;
      end
      if (reg_wr_i && hit(reg_addr_i, OFS_SUPPLY)) begin
         supply_cfg_nxt = reg_wdata_i;
      end
      if (reg_rd_i) begin
         if (hit(reg_addr_i, OFS_LOOP_BRAKE)) begin
            rdata_nxt = loop_cfg_r;
         end else if (hit(reg_addr_i, OFS_SUPPLY)) begin
            rdata_nxt = supply_cfg_r;
         end else begin
            rdata_nxt = RDATA_UNMAPPED;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         loop_cfg_r <= RST_LOOP_BRAKE;
         supply_cfg_r <= RST_SUPPLY;
         rdata_r <= RDATA_UNMAPPED;
      end else begin
         loop_cfg_r <= loop_cfg_nxt;
         supply_cfg_r <= supply_cfg_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   logic cfg_open;
   logic cfg_hybrid;
   logic cfg_auto_stop;
   logic cfg_stop_idle;
   logic cfg_slope;

   assign cfg_open = loop_cfg_r[BIT_OPEN_LOOP];
   assign cfg_hybrid = loop_cfg_r[BIT_HYBRID];
   assign cfg_auto_stop = loop_cfg_r[BIT_OPEN_LOOP_AUTO_STOP];
   assign cfg_stop_idle = loop_cfg_r[BIT_STOP_BEFORE_IDLE];
   assign cfg_slope = loop_cfg_r[BIT_SLOPE_GATE];

   // ---------------------------------------------------------------
   // Motion and slope gate
   // ---------------------------------------------------------------
   hlb_gate_if gif ();

   assign gif.sample = sample_i;
   assign gif.sample_valid = sample_valid_i;
   assign gif.bemf = bemf_i;

   hlb_gate #(
      .MOTION_LVL(MOTION_THRESH),
      .SLOPE_LVL(SLOPE_THRESH)
   ) u_gate (
      .clk_i(clk_sys_i),
      .rst_n_i(rst_n),
      .gif(gif.gate)
   );

   // ---------------------------------------------------------------
   // Standby sequencing and drive decision
   // ---------------------------------------------------------------
   hlb_state_t state_r;
   hlb_state_t state_nxt;
   logic loop_open_r;
   logic loop_open_nxt;
   logic hybrid_r;
   logic hybrid_nxt;
   logic brake_r;
   logic brake_nxt;
   logic signed [7:0] drive_r;
   logic signed [7:0] drive_nxt;
   logic sample_not_pos;

   assign sample_not_pos = (sample_i <= 8'sh00);

   always_comb begin
      state_nxt = state_r;
      loop_open_nxt = 1'b0;
      hybrid_nxt = 1'b0;
      brake_nxt = 1'b0;
      drive_nxt = 8'sh00;
      case (state_r)
         HLB_RUN: begin
            if (standby_req) begin
               if (cfg_stop_idle && playing_i && gif.moving) begin
                  state_nxt = HLB_BRAKE;
               end else begin
                  state_nxt = HLB_STANDBY;
               end
            end
            if (cfg_open) begin
               if (cfg_auto_stop && sample_not_pos) begin
                  brake_nxt = 1'b1;
               end else begin
                  loop_open_nxt = 1'b1;
                  drive_nxt = sample_i;
               end
            end else if (cfg_hybrid) begin
               if (cfg_slope && !gif.slope_big) begin
                  loop_open_nxt = 1'b1;
               end else begin
                  hybrid_nxt = 1'b1;
               end
               drive_nxt = sample_i;
            end else begin
               drive_nxt = sample_i;
            end
         end
         HLB_BRAKE: begin
            brake_nxt = 1'b1;
            if (!gif.moving) begin
               state_nxt = HLB_STANDBY;
            end
         end
         HLB_STANDBY: begin
            if (wake_i) begin
               state_nxt = HLB_RUN;
            end
         end
         default: begin
            state_nxt = HLB_STANDBY;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= HLB_RUN;
         loop_open_r <= 1'b0;
         hybrid_r <= 1'b0;
         brake_r <= 1'b0;
         drive_r <= 8'sh00;
      end else begin
         state_r <= state_nxt;
         loop_open_r <= loop_open_nxt;
         hybrid_r <= hybrid_nxt;
         brake_r <= brake_nxt;
         drive_r <= drive_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   logic standby_r;

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         standby_r <= 1'b0;
      end else begin
         standby_r <= (state_nxt == HLB_STANDBY);
      end
   end

   assign reg_rdata_o = rdata_r;
   assign loop_open_o = loop_open_r;
   assign hybrid_active_o = hybrid_r;
   assign brake_o = brake_r;
   assign drive_sample_o = drive_r;
   assign standby_o = standby_r;
   assign lra_select_o = loop_cfg_r[BIT_LRA_SELECT];
   assign supply_saver_enable_o = supply_cfg_r[POS_SUPPLY_SAVER +: W_SUPPLY_SAVER];
   assign low_supply_threshold_o = supply_cfg_r[POS_LOW_SUPPLY +: W_LOW_SUPPLY];

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   AST_CLOSED_FULL: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (state_r == HLB_RUN && !cfg_open && !cfg_hybrid) |=> (!loop_open_o && !hybrid_active_o))
      else $error("Closed loop select did not give closed loop");

   AST_HYBRID_ON: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (state_r == HLB_RUN && !cfg_open && cfg_hybrid && !cfg_slope) |=> hybrid_active_o)
      else $error("Hybrid loop not active");

   AST_OL_BRAKE: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (state_r == HLB_RUN && cfg_open && cfg_auto_stop && sample_i <= 8'sh00)
      |=> (brake_o && !loop_open_o))
      else $error("Open loop auto stop did not brake");

   AST_OL_PLAY: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (state_r == HLB_RUN && cfg_open && cfg_auto_stop && sample_i > 8'sh00)
      |=> (loop_open_o && !brake_o && drive_sample_o == $past(sample_i)))
      else $error("Positive sample not played open loop");

   AST_OL_NO_BRAKE: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (state_r == HLB_RUN && cfg_open && !cfg_auto_stop) |=> (!brake_o && loop_open_o))
      else $error("Braking without open loop auto stop");

   AST_IDLE_DIRECT: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (state_r == HLB_RUN && standby_req && !cfg_stop_idle)
      |=> (state_r == HLB_STANDBY && standby_o) ##1 !brake_o)
      else $error("Standby not entered at once");

   AST_IDLE_BRAKE: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (state_r == HLB_RUN && standby_req && cfg_stop_idle && playing_i && gif.moving)
      |=> (state_r == HLB_BRAKE && !standby_o) ##1 brake_o)
      else $error("No brake before standby");

   AST_IDLE_STILL: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (state_r == HLB_RUN && standby_req && cfg_stop_idle && !gif.moving)
      |=> state_r == HLB_STANDBY)
      else $error("Still actuator was braked");

   AST_BRAKE_END: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (state_r == HLB_BRAKE && !gif.moving) |=> (state_r == HLB_STANDBY && standby_o))
      else $error("Brake did not end in standby");

   AST_SLOPE_OPEN: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (state_r == HLB_RUN && !cfg_open && cfg_hybrid && cfg_slope && !gif.slope_big)
      |=> (loop_open_o && !hybrid_active_o))
      else $error("Small step left open loop");

   AST_SLOPE_IGNORED: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (state_r == HLB_RUN && !cfg_open && !cfg_hybrid && cfg_slope) |=> !loop_open_o)
      else $error("Slope gate acted without hybrid loop");
endmodule

//--- sim/hlb_actuator.sv
// Behavioural actuator model that turns drive and braking into a motion level
module hlb_actuator (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic brake_i,
   input wire logic signed [7:0] drive_i,
   input wire logic kick_i,
   output logic [7:0] bemf_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // Motion level: braking stops fast, coasting slowly, drive sets it
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bemf_o <= 8'h00;
      end else if (brake_i) begin
         bemf_o <= (bemf_o > 8'h08) ? bemf_o - 8'h08 : 8'h00;
      end else if (kick_i) begin
         bemf_o <= 8'h40;
      end else if (drive_i != 8'sh00) begin
         bemf_o <= drive_i[7] ? 8'(-drive_i) : drive_i;
      end else if (bemf_o != 8'h00) begin
         bemf_o <= bemf_o - 8'h01;
      end
   end
endmodule

//--- sim/haptic_loop_brake_config_test.sv
// Self-checking bench for the loop and brake configuration block
module haptic_loop_brake_config_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i = 1'b0, reset_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, bemf_i;
   logic signed [7:0] sample_i = 8'sh00, drive_sample_o;
   logic sample_valid_i = 1'b0, playing_i = 1'b0, idle_timer_req_i = 1'b0, kick = 1'b0;
   logic pin_level_mode_i = 1'b0, trigger_or_irq_pin_i = 1'b1, wake_i = 1'b0;
   logic loop_open_o, hybrid_active_o, brake_o, standby_o, lra_select_o;
   logic [1:0] supply_saver_enable_o;
   logic [2:0] low_supply_threshold_o;
   int n_mismatch = 0, cmp_count = 0, cyc = 0, seed = 78109, i, j, s, c, nb;
   logic [7:0] rv, d;
   logic found;
   int cfgs[6] = '{8'h88, 8'hA8, 8'hC8, 8'hD8, 8'h8C, 8'h48};

   hlb_top uut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .sample_i(sample_i), .sample_valid_i(sample_valid_i),
      .bemf_i(bemf_i), .playing_i(playing_i), .idle_timer_req_i(idle_timer_req_i),
      .pin_level_mode_i(pin_level_mode_i), .trigger_or_irq_pin_i(trigger_or_irq_pin_i),
      .wake_i(wake_i), .loop_open_o(loop_open_o), .hybrid_active_o(hybrid_active_o),
      .brake_o(brake_o), .drive_sample_o(drive_sample_o), .standby_o(standby_o),
      .lra_select_o(lra_select_o), .supply_saver_enable_o(supply_saver_enable_o),
      .low_supply_threshold_o(low_supply_threshold_o));
   hlb_actuator act (.clk_i(clk_sys_i), .rst_n_i(reset_n_i), .brake_i(brake_o),
      .drive_i(drive_sample_o), .kick_i(kick), .bemf_o(bemf_i));

   // ---------------------------------------------------------------
   // Clock, timeout and shared tasks
   // ---------------------------------------------------------------
   initial begin
      forever #2 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         close_out();
      end
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n = 1);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      reg_addr_i = a;
      reg_wdata_i = v;
      reg_wr_i = 1'b1;
      tick();
      reg_wr_i = 1'b0;
      tick(2);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      tick();
      v = reg_rdata_o;
      reg_rd_i = 1'b0;
      tick();
   endtask
   // Reference drive outcome: loop open, hybrid, brake, driven sample
   function automatic logic [10:0] exp_drv(input int cf, input int sv);
      if (cf[6]) begin
         if (cf[4] && $signed(sv[7:0]) <= 0) return 11'h100;
         return {3'b100, sv[7:0]};
      end
      return {1'b0, cf[5], 1'b0, sv[7:0]};
   endfunction
   // Standby request with a chosen brake setting, motion and source
   task automatic stby(input logic bit3, input logic moving, input logic by_pin,
         input logic play);
      wr(8'h08, {4'h8, bit3, 3'b000});
      playing_i = play;
      sample_i = 8'sh00;
      tick(70);
      kick = moving;
      tick();
      kick = 1'b0;
      pin_level_mode_i = by_pin;
      tick(3);
      if (by_pin) trigger_or_irq_pin_i = 1'b0;
      else idle_timer_req_i = 1'b1;
      tick();
      idle_timer_req_i = 1'b0;
      nb = 0;
      for (i = 0; i < 60 && standby_o !== 1'b1; i++) begin
         nb += (brake_o === 1'b1);
         tick();
      end
      chk(nb > 0, bit3 && moving && play);
      tick();
      chk({standby_o, brake_o, drive_sample_o}, 16'h0200);
      wake_i = 1'b1;
      tick();
      wake_i = 1'b0;
      trigger_or_irq_pin_i = 1'b1;
      pin_level_mode_i = 1'b0;
      playing_i = 1'b0;
      tick(2);
      chk(standby_o, 1'b0);
      $display("test standby %0d%0d%0d%0d done", bit3, moving, by_pin, play);
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      tick(16);
      reset_n_i = 1'b1;
      tick(3);
      chk(lra_select_o, 1'b1);
      rd(8'h08, rv);
      chk(rv, 8'h88);
      rd(8'h09, rv);
      chk(rv, 8'h00);
      d = $random(seed);
      wr(8'h09, d);
      chk({supply_saver_enable_o, low_supply_threshold_o}, {d[7:6], d[2:0]});
      rd(8'h09, rv);
      chk(rv, d);
      wr(8'h0A, 8'h5A);
      rd(8'h0A, rv);
      chk(rv, 8'h00);
      rd(8'h08, rv);
      chk(rv, 8'h88);
      $display("test registers done");
      for (j = 0; j < 6; j++) begin
         c = cfgs[j];
         wr(8'h08, c[7:0]);
         chk(lra_select_o, c[7]);
         for (i = 0; i < 8; i++) begin
            s = (i == 0) ? 0 : (i == 1) ? -1 : (i == 2) ? 127 : (i == 3) ? -128 : $random(seed);
            sample_i = s[7:0];
            sample_valid_i = 1'b1;
            tick();
            chk({loop_open_o, hybrid_active_o, brake_o, drive_sample_o},
               exp_drv(c, s));
         end
      end
      $display("test drive table done");
      wr(8'h08, 8'hAC);
      sample_i = 8'sh0A;
      tick(6);
      chk(loop_open_o, 1'b1);
      sample_i = 8'sh64;
      found = 1'b0;
      for (i = 0; i < 8; i++) begin
         tick();
         found |= (loop_open_o === 1'b0);
      end
      chk(found, 1'b1);
      sample_valid_i = 1'b0;
      $display("test slope gate done");
      stby(1'b1, 1'b1, 1'b0, 1'b1);
      stby(1'b1, 1'b0, 1'b0, 1'b1);
      stby(1'b0, 1'b1, 1'b0, 1'b1);
      stby(1'b1, 1'b1, 1'b0, 1'b0);
      stby(1'b1, 1'b1, 1'b1, 1'b1);
      close_out();
   end
endmodule
